// ### rfsw_bus_master.sv
// behavioural two-wire serial bus master that drives the route decoder
`timescale 1ns/1ps
`default_nettype none
module rfsw_bus_master (
	input wire logic clk_i, // bench clock, 40 ns
	input wire logic sdata_i, // resolved data wire
	output logic sclk_o, // serial clock, still between frames
	output logic sdata_o, // data value while master drives
	output logic sdata_oe_o // high while master drives data
);
	logic sclk_ff = 1'b0;
	logic sdata_ff = 1'b0;
	logic oe_ff = 1'b1;
	logic par_seen = 1'b0; // parity bit of the last read, odd over the data byte
	assign sclk_o = sclk_ff;
	assign sdata_o = sdata_ff;
	assign sdata_oe_o = oe_ff;
	// ----------------------------------------------------------------
	// bit level
	// ----------------------------------------------------------------
	// one 320 ns period: data moves while high, slave samples on the fall
	task automatic cyc(input logic b);
		sclk_ff <= 1'b1;
		sdata_ff <= b;
		repeat (4) @(posedge clk_i);
		sclk_ff <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	// start condition: data pulses high with the clock low
	// drive enable is already back on here, restored at the end of every read
	task automatic ssc();
		sdata_ff <= 1'b1;
		repeat (4) @(posedge clk_i);
		sdata_ff <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	// n bits msb first, then odd parity, spoilt on request
	task automatic field(input logic [11:0] v, input int n, input logic bad);
		logic p;
		p = 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			p = p ^ v[i];
			cyc(v[i]);
		end
		cyc(p ^ bad);
	endtask
	// ----------------------------------------------------------------
	// frames
	// ----------------------------------------------------------------
	task automatic wr(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] d,
		input logic bad);
		ssc();
		field({sa, 3'b010, a}, 12, 1'b0);
		field({4'h0, d}, 8, bad);
		cyc(1'b0);
	endtask
	// short mapping write: seven data bits ride in the command
	task automatic wr0(input logic [3:0] sa, input logic [6:0] d);
		ssc();
		field({sa, 1'b1, d}, 12, 1'b0);
		cyc(1'b0);
	endtask
	// sampled late in the low half since the slave answers through synchronisers
	task automatic rd(input logic [3:0] sa, input logic [4:0] a, output logic [7:0] d);
		ssc();
		field({sa, 3'b011, a}, 12, 1'b0);
		cyc(1'b0);
		oe_ff <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			cyc(1'b0);
			d[i] = sdata_i;
		end
		cyc(1'b0);
		par_seen = sdata_i;
		cyc(1'b0);
		repeat (4) @(posedge clk_i);
		oe_ff <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ### rfsw_pkg.sv
// constants and carrier types for the rf switch route decoder
package rfsw_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_MAPPING = 5'h00;
	localparam logic [4:0] ADDR_ROUTE = 5'h01;
	localparam logic [4:0] ADDR_STATUS = 5'h1a;
	localparam logic [7:0] MAPPING_RST = 8'h00;
	localparam logic [7:0] ROUTE_RST = 8'h00;
	localparam int MAP_CROSS_BIT = 0;
	localparam int STATUS_SWRST_BIT = 7;

	// ----------------------------------------------------------------
	// serial frame layout
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_LAST_BIT = 4'hc; // 12 command bits then parity
	localparam logic [3:0] DATA_LAST_BIT = 4'h8; // 8 data bits then parity
	localparam logic [3:0] RD_PARK_BIT = 4'h9; // bus park after read parity
	localparam logic [3:0] BROADCAST_SID = 4'h0;
	localparam logic [1:0] CMD_REG_WRITE = 2'b10;
	localparam logic [1:0] CMD_REG_READ = 2'b11;

	// ----------------------------------------------------------------
	// route code groups (bits 5:4)
	// ----------------------------------------------------------------
	localparam logic [1:0] GRP_SINGLE_ONE = 2'b00;
	localparam logic [1:0] GRP_DUAL_LOW_ONE = 2'b01;
	localparam logic [1:0] GRP_DUAL_HIGH_ONE = 2'b10;
	localparam logic [1:0] GRP_SINGLE_TWO = 2'b11;

	// switch drive: one-hot input selection per rf output
	typedef struct packed {
		logic [3:0] to_one; // rf_input_one..four onto rf_output_one
		logic [3:0] to_two; // rf_input_one..four onto rf_output_two
	} rfsw_route_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CMD,
		ST_WDATA,
		ST_RPARK,
		ST_RDATA
	} rfsw_state_t;
endpackage

// ### rfsw_route_decoder.sv
// rf switch route decoder with two-wire serial register access
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1 - mapping bit 0 selects direct (0, default) or crossed routing; other bits ignored
// RQ2 - route register bits 7:6 never affect the decoded switch state
// RQ3 - route bits 5:0 all zero isolate both outputs in either mapping
// RQ4 - direct, group 00, one input bit set: that input to output one only
// RQ5 - direct, group 11, one input bit set: that input to output two only
// RQ6 - direct, group 01, two bits: lower input to output one, higher to two
// RQ7 - direct, group 10, two bits: higher input to output one, lower to two
// RQ8 - crossed mapping decodes identically but swaps the two outputs
// RQ9 - slave identity chosen by a select pin; control over clock and data lines
// RQ10 - mapping register at address 0x00, readable and writable
// RQ11 - route register at address 0x01, readable, writable, resets to zero
// RQ12 - writing status bit 7 as one restores all registers to defaults
// RQ13 - any undefined route code isolates every path
// RQ14 - switch drive changes only after a complete parity-clean write
module rfsw_route_decoder #(
	parameter logic [3:0] SID_PIN_LOW = 4'h6, // arbitrary value
	parameter logic [3:0] SID_PIN_HIGH = 4'h7 // arbitrary value
) (
	input wire logic clk_sys_i, // 25 mhz system clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic sid_sel_i, // slave identity select pin
	input wire logic sclk_i, // serial bus clock pin
	input wire logic sdata_i, // serial data pin, input side
	output logic sdata_o, // serial data pin, output side
	output logic sdata_oe_o, // serial data drive enable
	output rfsw_pkg::rfsw_route_t route_o // switch drive, registered
);
	// ----------------------------------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [2:0] meta_ff;
	logic [2:0] sync_ff;
	logic sclk_d_ff;
	logic sdata_d_ff;
	logic sclk_rise;
	logic sclk_fall;
	logic ssc_seen;
	logic [3:0] own_sid;

	// two flops on every pin before any logic looks at it
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			meta_ff <= 3'h0;
			sync_ff <= 3'h0;
			sclk_d_ff <= 1'b0;
			sdata_d_ff <= 1'b0;
		end else begin
			meta_ff <= {sid_sel_i, sdata_i, sclk_i};
			sync_ff <= meta_ff;
			sclk_d_ff <= sync_ff[0];
			sdata_d_ff <= sync_ff[1];
		end
	end

	assign sclk_rise = sync_ff[0] && !sclk_d_ff;
	assign sclk_fall = !sync_ff[0] && sclk_d_ff;
	// data only moves while clock is high, so a rise with clock low starts a frame
	assign ssc_seen = sync_ff[1] && !sdata_d_ff && !sync_ff[0] && !sdata_oe_o;
	assign own_sid = sync_ff[2] ? SID_PIN_HIGH : SID_PIN_LOW; // RQ9

	// ----------------------------------------------------------------
	// frame receiver
	// ----------------------------------------------------------------
	rfsw_pkg::rfsw_state_t st_ff;
	logic [3:0] cnt_ff;
	logic [11:0] shift_ff;
	logic [4:0] addr_ff;
	logic [7:0] rd_word_ff;
	logic wr_fire_ff;
	logic [4:0] wr_addr_ff;
	logic [7:0] wr_data_ff;
	logic [7:0] map_ff;
	logic [7:0] rt_ff;
	logic [12:0] frame;
	logic [8:0] dframe;
	logic sid_hit;

	assign frame = {shift_ff, sync_ff[1]};
	assign dframe = {shift_ff[7:0], sync_ff[1]};
	assign sid_hit = (frame[12:9] == own_sid) || (frame[12:9] == rfsw_pkg::BROADCAST_SID);

	// register writes leave here only once parity has checked out
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			st_ff <= rfsw_pkg::ST_IDLE;
			cnt_ff <= 4'h0;
			shift_ff <= 12'h000;
			addr_ff <= 5'h00;
			rd_word_ff <= 8'h00;
			wr_fire_ff <= 1'b0;
			wr_addr_ff <= 5'h00;
			wr_data_ff <= 8'h00;
		end else begin
			wr_fire_ff <= 1'b0;
			if (ssc_seen) begin
				st_ff <= rfsw_pkg::ST_CMD;
				cnt_ff <= 4'h0;
			end else if (sclk_fall) begin
				shift_ff <= frame[11:0];
				cnt_ff <= cnt_ff + 4'h1;
				unique case (st_ff)
					rfsw_pkg::ST_IDLE: begin
						cnt_ff <= 4'h0;
					end
					rfsw_pkg::ST_CMD: begin
						if (cnt_ff == rfsw_pkg::CMD_LAST_BIT) begin
							st_ff <= rfsw_pkg::ST_IDLE;
							cnt_ff <= 4'h0;
							addr_ff <= frame[5:1];
							if (^frame && sid_hit) begin // RQ14
								if (frame[8]) begin
									// short write straight into the mapping register
									wr_fire_ff <= 1'b1;
									wr_addr_ff <= rfsw_pkg::ADDR_MAPPING;
									wr_data_ff <= {1'b0, frame[7:1]};
								end else if (frame[7:6] == rfsw_pkg::CMD_REG_WRITE) begin
									st_ff <= rfsw_pkg::ST_WDATA;
								end else if (frame[7:6] == rfsw_pkg::CMD_REG_READ &&
									frame[12:9] == own_sid) begin
									st_ff <= rfsw_pkg::ST_RPARK;
								end
							end
						end
					end
					rfsw_pkg::ST_WDATA: begin
						if (cnt_ff == rfsw_pkg::DATA_LAST_BIT) begin
							st_ff <= rfsw_pkg::ST_IDLE;
							cnt_ff <= 4'h0;
							wr_fire_ff <= ^dframe; // RQ14
							wr_addr_ff <= addr_ff;
							wr_data_ff <= dframe[8:1];
						end
					end
					rfsw_pkg::ST_RPARK: begin
						st_ff <= rfsw_pkg::ST_RDATA;
						cnt_ff <= 4'h0;
						unique case (addr_ff)
							rfsw_pkg::ADDR_MAPPING: rd_word_ff <= map_ff; // RQ10
							rfsw_pkg::ADDR_ROUTE: rd_word_ff <= rt_ff; // RQ11
							default: rd_word_ff <= 8'h00;
						endcase
					end
					rfsw_pkg::ST_RDATA: begin
						if (cnt_ff == rfsw_pkg::RD_PARK_BIT) begin
							st_ff <= rfsw_pkg::ST_IDLE;
							cnt_ff <= 4'h0;
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// read data driver
	// ----------------------------------------------------------------
	// bits launch on clock rise; park bit driven low, released after the fall
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sdata_o <= 1'b0;
			sdata_oe_o <= 1'b0;
		end else if (st_ff != rfsw_pkg::ST_RDATA) begin
			sdata_oe_o <= 1'b0;
			sdata_o <= 1'b0;
		end else if (sclk_rise) begin
			sdata_oe_o <= 1'b1;
			if (cnt_ff < rfsw_pkg::DATA_LAST_BIT) begin
				sdata_o <= rd_word_ff[3'h7 - cnt_ff[2:0]];
			end else if (cnt_ff == rfsw_pkg::DATA_LAST_BIT) begin
				sdata_o <= ~^rd_word_ff;
			end else begin
				sdata_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// status bit 7 is not stored, and a read of the status address returns zero, so it never reads back as one
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			map_ff <= rfsw_pkg::MAPPING_RST;
			rt_ff <= rfsw_pkg::ROUTE_RST; // RQ11
		end else if (wr_fire_ff) begin
			unique case (wr_addr_ff)
				rfsw_pkg::ADDR_MAPPING: map_ff <= wr_data_ff; // RQ10
				rfsw_pkg::ADDR_ROUTE: rt_ff <= wr_data_ff; // RQ11
				rfsw_pkg::ADDR_STATUS: begin
					if (wr_data_ff[rfsw_pkg::STATUS_SWRST_BIT]) begin
						map_ff <= rfsw_pkg::MAPPING_RST; // RQ12
						rt_ff <= rfsw_pkg::ROUTE_RST; // RQ12
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// route decode
	// ----------------------------------------------------------------
	rfsw_pkg::rfsw_route_t nxt_route;
	logic [3:0] in_bits;
	logic [3:0] low_bit;
	logic [3:0] high_bit;
	logic one_set;
	logic two_set;

	assign in_bits = rt_ff[3:0]; // RQ2
	assign low_bit = in_bits & (~in_bits + 4'h1);
	assign high_bit = in_bits ^ low_bit;
	assign one_set = (in_bits != 4'h0) && (high_bit == 4'h0);
	assign two_set = (high_bit != 4'h0) && ((high_bit & (high_bit - 4'h1)) == 4'h0);

	// anything not in the table falls through to isolation
	always_comb begin
		nxt_route = '0; // RQ3 RQ13
		unique case (rt_ff[5:4])
			rfsw_pkg::GRP_SINGLE_ONE: if (one_set) nxt_route.to_one = in_bits; // RQ4
			rfsw_pkg::GRP_SINGLE_TWO: if (one_set) nxt_route.to_two = in_bits; // RQ5
			rfsw_pkg::GRP_DUAL_LOW_ONE: begin
				if (two_set) begin
					nxt_route.to_one = low_bit; // RQ6
					nxt_route.to_two = high_bit;
				end
			end
			rfsw_pkg::GRP_DUAL_HIGH_ONE: begin
				if (two_set) begin
					nxt_route.to_one = high_bit; // RQ7
					nxt_route.to_two = low_bit;
				end
			end
		endcase
		if (map_ff[rfsw_pkg::MAP_CROSS_BIT]) begin // RQ1
			nxt_route = {nxt_route.to_two, nxt_route.to_one}; // RQ8
		end
	end

	// registered so decode glitches never reach the switch drivers
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			route_o <= '0;
		end else begin
			route_o <= nxt_route;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	a_iso_zero: assert property (rt_ff[5:0] == 6'h00 |=> route_o == '0) // RQ3
		else $error("zero route code did not isolate");
	a_single_one: assert property (!map_ff[0] && rt_ff[5:4] == 2'b00 && $onehot(rt_ff[3:0])
		|=> route_o.to_one == $past(rt_ff[3:0]) && route_o.to_two == 4'h0) // RQ4
		else $error("single path to output one wrong");
	a_single_two: assert property (!map_ff[0] && rt_ff[5:4] == 2'b11 && $onehot(rt_ff[3:0])
		|=> route_o.to_two == $past(rt_ff[3:0]) && route_o.to_one == 4'h0) // RQ5
		else $error("single path to output two wrong");
	a_dual_low: assert property (!map_ff[0] && rt_ff[5:4] == 2'b01 &&
		$countones(rt_ff[3:0]) == 2 |=> $onehot(route_o.to_one) &&
		$onehot(route_o.to_two) && route_o.to_one < route_o.to_two) // RQ6
		else $error("dual low-first mapping wrong");
	a_dual_high: assert property (!map_ff[0] && rt_ff[5:4] == 2'b10 &&
		$countones(rt_ff[3:0]) == 2 |=> $onehot(route_o.to_one) &&
		$onehot(route_o.to_two) && route_o.to_one > route_o.to_two) // RQ7
		else $error("dual high-first mapping wrong");
	a_cross_swap: assert property (map_ff[0] && rt_ff[5:0] == 6'h01
		|=> route_o.to_two == 4'h1 && route_o.to_one == 4'h0) // RQ8
		else $error("crossed mapping did not swap outputs");
	a_top_ignored: assert property ($stable(rt_ff[5:0]) && $stable(map_ff[0])
		|=> $stable(route_o)) // RQ2
		else $error("ignored bits changed the route");
	a_undef_iso: assert property (rt_ff[5:4] == 2'b00 && !$onehot(rt_ff[3:0])
		|=> route_o == '0) // RQ13
		else $error("undefined code closed a path");
	a_soft_reset: assert property (wr_fire_ff && wr_addr_ff == 5'h1a && wr_data_ff[7]
		|=> map_ff == 8'h00 && rt_ff == 8'h00) // RQ12
		else $error("software reset left registers set");
	a_no_partial: assert property (!wr_fire_ff |=> $stable(rt_ff) && $stable(map_ff)) // RQ14
		else $error("register changed without a complete write");
	a_map_write: assert property (wr_fire_ff && wr_addr_ff == 5'h00
		|=> map_ff == $past(wr_data_ff)) // RQ10
		else $error("mapping register write lost");

	c_dual_through: cover property (route_o.to_one != 4'h0 && route_o.to_two != 4'h0);
	c_crossed: cover property (map_ff[0] && route_o.to_two != 4'h0);
	c_read_frame: cover property (st_ff == rfsw_pkg::ST_RDATA ##1 st_ff == rfsw_pkg::ST_IDLE);
	c_route_write: cover property (wr_fire_ff && wr_addr_ff == 5'h01);
endmodule
`default_nettype wire

// ### rfsw_route_decoder_tb.sv
// self-checking testbench for the rf switch route decoder
`timescale 1ns/1ps
`default_nettype none
module rfsw_route_decoder_tb;
	localparam logic [3:0] SID_LO = 4'h3; // arbitrary value
	localparam logic [3:0] SID_HI = 4'h9; // arbitrary value
	// rows: mapping, route code, expected {to_one, to_two}
	localparam logic [23:0] ROWS [14] = '{24'h00_00_00, 24'h00_01_10, 24'h00_08_80,
		24'h00_32_02, 24'h00_13_12, 24'h00_1c_48, 24'h00_29_81, 24'h00_d3_12,
		24'hfe_13_12, 24'h00_64_00, 24'h00_3f_00, 24'h01_13_21, 24'hff_f8_80, 24'h01_00_00};
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sid_sel_i = 1'b0;
	logic m_sclk, m_sdata, m_oe, d_sdata, d_oe, wire_sdata;
	rfsw_pkg::rfsw_route_t route;
	logic [7:0] rdv;
	int fails = 0;
	int samples_checked = 0;
	// 25 mhz clock
	always #20 clk_sys_i = ~clk_sys_i;
	// pull-down holds the wire low when nobody drives
	assign wire_sdata = d_oe ? d_sdata : (m_oe ? m_sdata : 1'b0);
	rfsw_route_decoder #(.SID_PIN_LOW(SID_LO), .SID_PIN_HIGH(SID_HI)) dut_u (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sid_sel_i(sid_sel_i),
		.sclk_i(m_sclk), .sdata_i(wire_sdata), .sdata_o(d_sdata),
		.sdata_oe_o(d_oe), .route_o(route));
	rfsw_bus_master master_u (.clk_i(clk_sys_i), .sdata_i(wire_sdata),
		.sclk_o(m_sclk), .sdata_o(m_sdata), .sdata_oe_o(m_oe));
	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// watchdog, about three times the expected run
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		fails++;
		end_of_test();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		chk(route, 8'h00);
		chk({7'h00, d_oe}, 8'h00);
		master_u.rd(SID_LO, rfsw_pkg::ADDR_MAPPING, rdv);
		chk(rdv, rfsw_pkg::MAPPING_RST);
		for (int i = 0; i < 14; i++) begin
			master_u.wr(SID_LO, rfsw_pkg::ADDR_MAPPING, ROWS[i][23:16], 1'b0);
			master_u.wr(SID_LO, rfsw_pkg::ADDR_ROUTE, ROWS[i][15:8], 1'b0);
			repeat (2) @(posedge clk_sys_i);
			chk(route, ROWS[i][7:0]);
			master_u.rd(SID_LO, rfsw_pkg::ADDR_ROUTE, rdv);
			chk(rdv, ROWS[i][15:8]);
			chk({7'h00, master_u.par_seen}, {7'h00, ~^ROWS[i][15:8]});
		end
		// full and short mapping writes read back
		master_u.wr(SID_LO, rfsw_pkg::ADDR_MAPPING, 8'ha5, 1'b0);
		master_u.rd(SID_LO, rfsw_pkg::ADDR_MAPPING, rdv);
		chk(rdv, 8'ha5);
		chk({7'h00, master_u.par_seen}, 8'h01);
		master_u.wr0(SID_LO, 7'h01);
		master_u.rd(SID_LO, rfsw_pkg::ADDR_MAPPING, rdv);
		chk(rdv, 8'h01);
		chk({7'h00, d_oe}, 8'h00);
		// spoilt parity, unmapped place and foreign identity change nothing
		master_u.wr(SID_LO, rfsw_pkg::ADDR_ROUTE, 8'h01, 1'b0);
		master_u.wr(SID_LO, rfsw_pkg::ADDR_ROUTE, 8'h08, 1'b1);
		master_u.wr(SID_LO, 5'h05, 8'h08, 1'b0);
		master_u.wr(SID_HI, rfsw_pkg::ADDR_ROUTE, 8'h08, 1'b0);
		chk(route, 8'h01);
		master_u.rd(SID_LO, 5'h05, rdv);
		chk(rdv, 8'h00);
		// select pin moves the identity; broadcast writes land too
		sid_sel_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		master_u.wr(SID_HI, rfsw_pkg::ADDR_ROUTE, 8'h08, 1'b0);
		chk(route, 8'h08);
		master_u.wr(4'h0, rfsw_pkg::ADDR_ROUTE, 8'h02, 1'b0);
		chk(route, 8'h02);
		// software reset restores defaults
		master_u.wr(SID_HI, rfsw_pkg::ADDR_STATUS, 8'h80, 1'b0);
		repeat (2) @(posedge clk_sys_i);
		chk(route, 8'h00);
		master_u.rd(SID_HI, rfsw_pkg::ADDR_MAPPING, rdv);
		chk(rdv, 8'h00);
		// a frame cut short inside its data writes nothing; the next start restarts
		master_u.ssc();
		master_u.field({SID_HI, 3'b010, rfsw_pkg::ADDR_ROUTE}, 12, 1'b0);
		master_u.field(12'h0ff, 4, 1'b0);
		master_u.cyc(1'b0);
		repeat (2) @(posedge clk_sys_i);
		chk(route, 8'h00);
		// second reset in mid-run
		master_u.wr(SID_HI, rfsw_pkg::ADDR_ROUTE, 8'h01, 1'b0);
		chk(route, 8'h10);
		rst_n_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		chk(route, 8'h00);
		master_u.rd(SID_HI, rfsw_pkg::ADDR_ROUTE, rdv);
		chk(rdv, rfsw_pkg::ROUTE_RST);
		end_of_test();
	end
endmodule
`default_nettype wire
